// File: pdes_pad_cell.sv
// One shared pad: owner select, driver mux, pull-up gate, input synchroniser.
// Assumes clk/reset_n of the system; all outputs are registered.
`timescale 1ns/1ps

module pdes_pad_cell (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic sel_peripheral,
  input  wire logic gpio_out,
  input  wire logic gpio_oe,
  input  wire logic periph_out,
  input  wire logic periph_oe,
  input  wire logic pullup_enable,
  input  wire logic pad_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup,
  output logic      pin_value
);

  logic pad_meta;
  logic next_out;
  logic next_oe;

  // Driver follows the selected owner
  always_comb begin
    if (sel_peripheral) begin
      next_out = periph_out;
      next_oe  = periph_oe;
    end else begin
      next_out = gpio_out;
      next_oe  = gpio_oe;
    end
  end

  // Registered pad drive
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;   // Undriven until configured
    end else begin
      pad_out <= next_out;
      pad_oe  <= next_oe;
    end
  end

  // Pull-up gate; up during reset like the pad itself
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_pullup <= 1'b1;
    end else begin
      pad_pullup <= pullup_enable;
    end
  end

  // Two-flop synchroniser for the pad level
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pad_meta  <= 1'b1;
      pin_value <= 1'b1;
    end else begin
      pad_meta  <= pad_in;
      pin_value <= pad_meta;
    end
  end

endmodule // pdes_pad_cell

// File: pdes_pad_partner.sv
// Board side of the eight shared pads: memories, serial partner, pull-ups.
// Assumes the bench never drives a pad the design drives.
`timescale 1ns/1ps

module pdes_pad_partner (
  input  wire logic       clk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic [7:0]      pad_in
);
  // Floating pads wander, so no stale level can pass for a real one
  logic [7:0] wander = 8'h5A;
  always @(posedge clk) begin
    wander <= ~wander;
  end
  // Design drive wins, then the outside party, then the pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & pad_pullup) | (~pad_oe & ~ext_en & ~pad_pullup & wander);
endmodule // pdes_pad_partner

// File: pdes_pin_sharing.sv
// Pin sharing for port D pins 0..5 (chip selects 2..7) and port E pins 0..1
// (serial channel 0 transmit and receive).
// Assumes control bits come from registers on clk; pad inputs are asynchronous.
//
// Behaviour
// - Each port D pin is separately an input or output in GPIO use.
// - In memory use, port D pins 0..5 carry chip selects 2 through 7.
// - Chip selects float while the bus is idle unless the bus drive bit is set.
// - After reset the port D pins come up as GPIO.
// - Clearing port D pull-up enable bit n disables pin n pull-up.
// - Port E pin 0 is serial channel 0 transmit when not GPIO.
// - After reset port E pin 0 defaults to serial transmit.
// - Clearing port E pull-up enable bit 0 disables pin 0 pull-up.
// - Port E pin 1 is serial receive, else a GPIO input or output.
// - Clearing port E pull-up enable bit 1 disables pin 1 pull-up.
`timescale 1ns/1ps
`include "pdes_regs.svh"

module pdes_pin_sharing (
  input  wire logic                  clk,
  input  wire logic                  reset_n,
  // Function selects, one bit per pin: 1 = peripheral
  input  wire pdes_pkg::pdes_port_d_t port_d_select,
  input  wire pdes_pkg::pdes_port_e_t port_e_select,
  // GPIO direction and data
  input  wire pdes_pkg::pdes_port_d_t port_d_direction,
  input  wire pdes_pkg::pdes_port_d_t port_d_data_out,
  input  wire pdes_pkg::pdes_port_e_t port_e_direction,
  input  wire pdes_pkg::pdes_port_e_t port_e_data_out,
  // Pull-up enables
  input  wire pdes_pkg::pdes_port_d_t port_d_pullup_enable,
  input  wire pdes_pkg::pdes_port_e_t port_e_pullup_enable,
  // External memory side
  input  wire logic [5:0]            chip_select_n,
  input  wire logic                  bus_active,
  input  wire logic                  bus_drive_bit,
  // Serial channel 0 side
  input  wire logic                  serial0_transmit,
  output logic                       serial0_receive,
  // Pads
  input  wire pdes_pkg::pdes_port_d_t port_d_pad_in,
  output pdes_pkg::pdes_port_d_t      port_d_pad_out,
  output pdes_pkg::pdes_port_d_t      port_d_pad_oe,
  output pdes_pkg::pdes_port_d_t      port_d_pad_pullup,
  input  wire pdes_pkg::pdes_port_e_t port_e_pad_in,
  output pdes_pkg::pdes_port_e_t      port_e_pad_out,
  output pdes_pkg::pdes_port_e_t      port_e_pad_oe,
  output pdes_pkg::pdes_port_e_t      port_e_pad_pullup,
  // Synchronised pin levels back to the GPIO data registers
  output pdes_pkg::pdes_port_d_t      port_d_pin_value,
  output pdes_pkg::pdes_port_e_t      port_e_pin_value
);

  pdes_pkg::pdes_port_d_t d_sel;
  pdes_pkg::pdes_port_e_t e_sel;
  pdes_pkg::pdes_port_d_t d_dir;
  pdes_pkg::pdes_port_d_t d_data;
  pdes_pkg::pdes_port_e_t e_dir;
  pdes_pkg::pdes_port_e_t e_data;
  pdes_pkg::pdes_port_d_t d_pullup;
  pdes_pkg::pdes_port_e_t e_pullup;
  logic                   cs_drive;
  pdes_pkg::pdes_port_e_t e_pin_value;
  logic                   rx_value;

  // Chip select drive: always while the bus runs, and when idle only with drive set
  function automatic logic cs_enable(input logic active, input logic drive);
    cs_enable = active | drive;
  endfunction

  // Owner decode shared by both ports
  function automatic logic is_peripheral(input logic sel);
    is_peripheral = (pdes_pkg::pdes_owner_e'(sel) == pdes_pkg::PDES_OWNER_PERIPHERAL);
  endfunction

  // Port D function select; GPIO out of reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      d_sel <= `PDES_D_SEL_RESET;
    end else begin
      d_sel <= port_d_select;
    end
  end

  // Port E function select; transmit pin starts on the serial channel
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      e_sel <= `PDES_E_SEL_RESET;
    end else begin
      e_sel <= port_e_select;
    end
  end

  // GPIO direction and data, registered so pads change on one edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      d_dir  <= `PDES_D_GPIO_RESET;
      d_data <= `PDES_D_GPIO_RESET;
      e_dir  <= `PDES_E_GPIO_RESET;
      e_data <= `PDES_E_GPIO_RESET;
    end else begin
      d_dir  <= port_d_direction;
      d_data <= port_d_data_out;
      e_dir  <= port_e_direction;
      e_data <= port_e_data_out;
    end
  end

  // Pull-up enables, all on out of reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      d_pullup <= `PDES_D_PULLUP_RESET;
      e_pullup <= `PDES_E_PULLUP_RESET;
    end else begin
      d_pullup <= port_d_pullup_enable;
      e_pullup <= port_e_pullup_enable;
    end
  end

  // Chip select enable; drive bit is software's to set, reset leaves it floating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cs_drive <= `PDES_BUS_DRIVE_RESET;
    end else begin
      cs_drive <= cs_enable(bus_active, bus_drive_bit);
    end
  end

  // Port D pads: chip selects 2..7 on pins 0..5
  genvar i;
  generate
    for (i = 0; i < `PDES_PORT_D_PINS; i++) begin : g_port_d
      pdes_pad_cell u_cell (
        .clk            (clk),
        .reset_n        (reset_n),
        .sel_peripheral (is_peripheral(d_sel[i])),
        .gpio_out       (d_data[i]),
        .gpio_oe        (d_dir[i]),
        .periph_out     (chip_select_n[i]),
        .periph_oe      (cs_drive),
        .pullup_enable  (d_pullup[i]),
        .pad_in         (port_d_pad_in[i]),
        .pad_out        (port_d_pad_out[i]),
        .pad_oe         (port_d_pad_oe[i]),
        .pad_pullup     (port_d_pad_pullup[i]),
        .pin_value      (port_d_pin_value[i])
      );
    end
  endgenerate

  // Port E pin 0: serial transmit, always driven when owned by the channel
  pdes_pad_cell u_e_tx (
    .clk            (clk),
    .reset_n        (reset_n),
    .sel_peripheral (is_peripheral(e_sel[`PDES_E_TX_BIT])),
    .gpio_out       (e_data[`PDES_E_TX_BIT]),
    .gpio_oe        (e_dir[`PDES_E_TX_BIT]),
    .periph_out     (serial0_transmit),
    .periph_oe      (1'b1),
    .pullup_enable  (e_pullup[`PDES_E_TX_BIT]),
    .pad_in         (port_e_pad_in[`PDES_E_TX_BIT]),
    .pad_out        (port_e_pad_out[`PDES_E_TX_BIT]),
    .pad_oe         (port_e_pad_oe[`PDES_E_TX_BIT]),
    .pad_pullup     (port_e_pad_pullup[`PDES_E_TX_BIT]),
    .pin_value      (e_pin_value[`PDES_E_TX_BIT])
  );

  // Port E pin 1: serial receive is an input, so the channel never drives it
  pdes_pad_cell u_e_rx (
    .clk            (clk),
    .reset_n        (reset_n),
    .sel_peripheral (is_peripheral(e_sel[`PDES_E_RX_BIT])),
    .gpio_out       (e_data[`PDES_E_RX_BIT]),
    .gpio_oe        (e_dir[`PDES_E_RX_BIT]),
    .periph_out     (1'b0),
    .periph_oe      (1'b0),
    .pullup_enable  (e_pullup[`PDES_E_RX_BIT]),
    .pad_in         (port_e_pad_in[`PDES_E_RX_BIT]),
    .pad_out        (port_e_pad_out[`PDES_E_RX_BIT]),
    .pad_oe         (port_e_pad_oe[`PDES_E_RX_BIT]),
    .pad_pullup     (port_e_pad_pullup[`PDES_E_RX_BIT]),
    .pin_value      (e_pin_value[`PDES_E_RX_BIT])
  );

  // Receive line idles high when GPIO owns the pin, so the channel sees no start bit
  always_comb begin
    rx_value = e_pin_value[`PDES_E_RX_BIT];
    if (!is_peripheral(e_sel[`PDES_E_RX_BIT])) begin
      rx_value = 1'b1;
    end
  end

  // Registered receive output and port E pin levels
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial0_receive  <= 1'b1;
      port_e_pin_value <= 2'h3;
    end else begin
      serial0_receive  <= rx_value;
      port_e_pin_value <= e_pin_value;
    end
  end

endmodule // pdes_pin_sharing

// File: pdes_pin_sharing_sva.sv
// Checker for the port D / port E pin sharing block, bound to its top module.
// Assumes control inputs are registered once and pads once more before they show.
`timescale 1ns/1ps

module pdes_pin_sharing_sva (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire pdes_pkg::pdes_port_d_t port_d_select,
  input wire pdes_pkg::pdes_port_d_t port_d_direction,
  input wire pdes_pkg::pdes_port_d_t port_d_data_out,
  input wire pdes_pkg::pdes_port_d_t port_d_pullup_enable,
  input wire pdes_pkg::pdes_port_e_t port_e_select,
  input wire pdes_pkg::pdes_port_e_t port_e_pullup_enable,
  input wire logic [5:0]             chip_select_n,
  input wire logic                   bus_active,
  input wire logic                   bus_drive_bit,
  input wire logic                   serial0_transmit,
  input wire pdes_pkg::pdes_port_d_t port_d_pad_in,
  input wire pdes_pkg::pdes_port_d_t port_d_pad_out,
  input wire pdes_pkg::pdes_port_d_t port_d_pad_oe,
  input wire pdes_pkg::pdes_port_d_t port_d_pad_pullup,
  input wire pdes_pkg::pdes_port_d_t port_d_pin_value,
  input wire pdes_pkg::pdes_port_e_t port_e_pad_out,
  input wire pdes_pkg::pdes_port_e_t port_e_pad_oe,
  input wire pdes_pkg::pdes_port_e_t port_e_pad_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Edges since reset; $past looks before release until this saturates
  logic [1:0] up_cnt;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up_cnt <= 2'h0;
    else if (up_cnt != 2'h3) up_cnt <= up_cnt + 2'h1;
  end

  sequence s_settled;
    up_cnt == 2'h3;
  endsequence
  // Transmit data held, so either latency of its path passes
  sequence s_tx_held;
    s_settled ##0 $past(serial0_transmit, 1) == $past(serial0_transmit, 2);
  endsequence

  a_d_pullup_gate: assert property (s_settled |->
    port_d_pad_pullup == $past(port_d_pullup_enable, 2)) else $error("port D pull-up wrong");
  a_e_pullup_gate: assert property (s_settled |->
    port_e_pad_pullup == $past(port_e_pullup_enable, 2)) else $error("port E pull-up wrong");
  a_gpio_d_dir: assert property (s_settled |->
    ((port_d_pad_oe ^ $past(port_d_direction, 2)) & ~$past(port_d_select, 2)) == 6'h00)
    else $error("port D GPIO direction wrong");
  a_gpio_d_data: assert property (s_settled |->
    ((port_d_pad_out ^ $past(port_d_data_out, 2)) & ~$past(port_d_select, 2)
     & $past(port_d_direction, 2)) == 6'h00) else $error("port D GPIO data wrong");
  a_cs_data_pass: assert property (s_settled |->
    ((port_d_pad_out ^ $past(chip_select_n, 1)) & $past(port_d_select, 2)) == 6'h00)
    else $error("chip select level wrong");
  a_cs_idle_float: assert property (s_settled |->
    ((port_d_pad_oe ^ {6{$past(bus_active, 2) | $past(bus_drive_bit, 2)}})
     & $past(port_d_select, 2)) == 6'h00) else $error("chip select enable wrong");
  a_tx_drive: assert property (s_tx_held ##0 $past(port_e_select[0], 2) |->
    port_e_pad_oe[0] && port_e_pad_out[0] == $past(serial0_transmit, 1))
    else $error("transmit pin not driven with serial data");
  a_rx_no_drive: assert property (s_settled ##0 $past(port_e_select[1], 2) |->
    !port_e_pad_oe[1]) else $error("receive pin driven");
  // First edge after release still uses the reset owners, before any input is seen
  a_reset_owner: assert property (up_cnt == 2'h1 |->
    port_e_pad_oe[0] && port_d_pad_oe == 6'h00 && port_d_pad_out == 6'h00)
    else $error("pad owners wrong after reset");
  a_d_pin_sync: assert property (s_settled |->
    port_d_pin_value == $past(port_d_pad_in, 2)) else $error("port D pin value wrong");
endmodule // pdes_pin_sharing_sva

bind pdes_pin_sharing pdes_pin_sharing_sva u_pdes_pin_sharing_sva (.*);

// File: pdes_pin_sharing_tb_top.sv
// Self-checking bench for the port D / port E pin sharing block.
// Assumes the checker is bound by its own file and the partner models the board.
`timescale 1ns/1ps
`include "pdes_regs.svh"
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_count++; \
  $display("BAD %s exp %h got %h", nm, exp, got); end end

module pdes_pin_sharing_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  pdes_pkg::pdes_port_d_t port_d_select, port_d_direction, port_d_data_out, port_d_pullup_enable;
  pdes_pkg::pdes_port_d_t port_d_pad_in, port_d_pad_out, port_d_pad_oe, port_d_pad_pullup;
  pdes_pkg::pdes_port_d_t port_d_pin_value;
  pdes_pkg::pdes_port_e_t port_e_select, port_e_direction, port_e_data_out, port_e_pullup_enable;
  pdes_pkg::pdes_port_e_t port_e_pad_in, port_e_pad_out, port_e_pad_oe, port_e_pad_pullup;
  pdes_pkg::pdes_port_e_t port_e_pin_value;
  logic [5:0]  chip_select_n;
  logic        bus_active, bus_drive_bit, serial0_transmit, serial0_receive;
  logic [48:0] stim;
  logic [7:0]  ext_en = 8'h00;
  logic [7:0]  ext_val;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;

  // All stimulus but ext_en lives in one vector so one edge updates it at once
  assign {port_d_select, port_d_direction, port_d_data_out, port_d_pullup_enable,
          port_e_select, port_e_direction, port_e_data_out, port_e_pullup_enable,
          chip_select_n, bus_active, bus_drive_bit, serial0_transmit, ext_val} = stim;

  pdes_pin_sharing u_pdes_pin_sharing (.*);
  pdes_pad_partner u_pdes_pad_partner (
    .clk(clk), .pad_out({port_e_pad_out, port_d_pad_out}), .pad_oe({port_e_pad_oe, port_d_pad_oe}),
    .pad_pullup({port_e_pad_pullup, port_d_pad_pullup}), .ext_en(ext_en), .ext_val(ext_val),
    .pad_in({port_e_pad_in, port_d_pad_in}));

  always #2.5 clk = ~clk;

  // Hang guard, far above the roughly 300 edges the tests need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      complete_run();
    end
  end

  function automatic logic [7:0] exp_oe();
    return {~port_e_select[1] & port_e_direction[1], port_e_select[0] | port_e_direction[0],
            (port_d_select & {6{bus_active | bus_drive_bit}}) | (~port_d_select & port_d_direction)};
  endfunction

  function automatic logic [7:0] exp_out();
    return {port_e_data_out[1], port_e_select[0] ? serial0_transmit : port_e_data_out[0],
            (port_d_select & chip_select_n) | (~port_d_select & port_d_data_out)};
  endfunction

  task automatic check_all(input string nm);
    logic [7:0] oe, out, pu, lvl, known;
    oe = exp_oe();
    out = exp_out();
    pu = {port_e_pullup_enable, port_d_pullup_enable};
    lvl = (oe & out) | (~oe & ext_en & ext_val) | (~oe & ~ext_en & pu);
    known = oe | ext_en | pu;
    `CHK("pad_oe", oe, {port_e_pad_oe, port_d_pad_oe})
    `CHK("pad_out", out & oe, {port_e_pad_out, port_d_pad_out} & oe)
    `CHK("pad_pullup", pu, {port_e_pad_pullup, port_d_pad_pullup})
    `CHK("pin_value", lvl & known, {port_e_pin_value, port_d_pin_value} & known)
    `CHK("serial0_receive", (port_e_select[1] ? lvl[7] : 1'b1) | ~known[7],
         serial0_receive | ~known[7])
    $display("test %s done", nm);
  endtask

  // Apply one setting, keep the board off driven pads, let it settle
  task automatic step(input logic [48:0] r, input logic [7:0] en, input string nm);
    @(posedge clk);
    stim <= r;
    @(posedge clk);
    ext_en <= en & ~exp_oe();
    repeat (5) @(posedge clk);
    @(negedge clk);
    check_all(nm);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [48:0] r;
    stim = {`PDES_D_SEL_RESET, `PDES_D_GPIO_RESET, `PDES_D_GPIO_RESET, `PDES_D_PULLUP_RESET,
            `PDES_E_SEL_RESET, `PDES_E_GPIO_RESET, `PDES_E_GPIO_RESET, `PDES_E_PULLUP_RESET,
            6'h3F, 1'h0, `PDES_BUS_DRIVE_RESET, 1'h1, 8'h00};
    void'($urandom(32'hFA33));
    repeat (12) @(posedge clk);
    `CHK("reset pad_oe", 8'h00, {port_e_pad_oe, port_d_pad_oe})
    reset_n <= 1'b1;
    step(stim, 8'h00, "reset defaults");
    for (int i = 0; i < 40; i++) begin
      r = 49'({$urandom, $urandom});
      // Corners first: idle bus floating, then held by the drive bit, then pull-ups off
      if (i < 2) begin
        r[48:43] = 6'h3F;
        r[10:9] = {1'b0, i[0]};
      end else if (i == 2) begin
        r[30:25] = 6'h00;
        r[18:17] = 2'h0;
      end
      step(r, 8'($urandom), $sformatf("random %0d", i));
    end
    complete_run();
  end
endmodule // pdes_pin_sharing_tb_top

// File: pdes_pkg.sv
// Types for the port D / port E pin sharing block.
// Assumes no other package; nothing is imported.
package pdes_pkg;

  // Owner of a shared pad
  typedef enum logic {
    PDES_OWNER_GPIO       = 1'b0,
    PDES_OWNER_PERIPHERAL = 1'b1
  } pdes_owner_e;

  typedef logic [5:0] pdes_port_d_t;
  typedef logic [1:0] pdes_port_e_t;

endpackage

// File: pdes_regs.svh
// Constants for the port D / port E pin sharing block.
// Assumes inclusion by pdes_pin_sharing.sv and the verification side only.
`ifndef PDES_REGS_SVH
`define PDES_REGS_SVH

// Pin counts
`define PDES_PORT_D_PINS        6
`define PDES_PORT_E_PINS        2
// Port E bit positions
`define PDES_E_TX_BIT           0
`define PDES_E_RX_BIT           1
// Reset values of the function selects: 0 = general-purpose I/O, 1 = peripheral
`define PDES_D_SEL_RESET        6'h00
`define PDES_E_SEL_RESET        2'h1
// Reset values of the pull-up enables and GPIO control
`define PDES_D_PULLUP_RESET     6'h3F
`define PDES_E_PULLUP_RESET     2'h3
`define PDES_D_GPIO_RESET       6'h00
`define PDES_E_GPIO_RESET       2'h0
// Reset value of the bus drive bit
`define PDES_BUS_DRIVE_RESET    1'h0

`endif
